// >>> pkg/balancing_alert_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef BALANCING_ALERT_DEFINES_SVH
`define BALANCING_ALERT_DEFINES_SVH

// ----------------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------------
`define AVS_ADDR_W 5
`define AVS_DATA_W 32
`define AVS_BE_W 4

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_BAL_CONTROL 5'h00
`define OFS_BAL_ALERT_SUMMARY 5'h04
`define OFS_CMD_REJECT 5'h08
`define OFS_IRQ_MASK 5'h0c
`define OFS_IRQ_STATUS 5'h10

// ----------------------------------------------------------------------
// balancing_alert_summary fields
// ----------------------------------------------------------------------
`define BIT_WATCHDOG_HALT 15
`define BIT_THERMAL_HALT 14
`define BIT_CALIB_HALT 13
`define BIT_PROGRESS 12
`define BIT_FINISHED 11
`define SUMMARY_LO 11
`define SUMMARY_RESET 16'h0000

// ----------------------------------------------------------------------
// command rejection and interrupt layout
// ----------------------------------------------------------------------
`define BIT_REJECTED 0
`define IRQ_LAYOUT 16'hf801
`define IRQ_RESET 16'h0000

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define BIT_TIMEOUT_DISABLE 0
`define BIT_THERMAL_ENABLE 1
`define NOTICE_CFG_LO 2
`define NOTICE_CFG_HI 3
`define CONTROL_RESET 4'h0

// ----------------------------------------------------------------------
// progress notice timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define NOTICE_SHORT_NS 50000
`define NOTICE_MID_NS 100000
`define NOTICE_LONG_NS 200000
`define NOTICE_SHORT_CYC (`NOTICE_SHORT_NS / `CLK_PERIOD_NS)
`define NOTICE_MID_CYC (`NOTICE_MID_NS / `CLK_PERIOD_NS)
`define NOTICE_LONG_CYC (`NOTICE_LONG_NS / `CLK_PERIOD_NS)
`define NOTICE_CNT_W 12

`endif

// >>> pkg/balancing_alert_pkg.sv
// types shared by the balancing alert status logic
`include "balancing_alert_defines.svh"

package balancing_alert_pkg;

    typedef enum logic [1:0] {
        MODE_MANUAL,
        MODE_DISCHARGE,
        MODE_AUTO
    } bal_mode_t;

    typedef enum logic {
        BUS_IDLE,
        BUS_ACK
    } bus_state_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [`AVS_ADDR_W-1:0] address;
        logic [`AVS_DATA_W-1:0] writedata;
        logic [`AVS_BE_W-1:0] byteenable;
    } avs_req_t;

    typedef struct packed {
        logic waitrequest;
        logic [`AVS_DATA_W-1:0] readdata;
    } avs_rsp_t;

    // engine condition and one-cycle event inputs
    typedef struct packed {
        logic active;
        bal_mode_t mode;
        logic watchdog_halt;
        logic thermal_halt;
        logic calib_halt;
        logic done_timer;
        logic done_undervoltage;
    } bal_event_t;

    typedef struct packed {
        logic scan_active;
        logic gate_scan_active;
        logic write_req;
    } prot_write_t;

endpackage

// >>> rtl/sticky_alert_bit.sv
// one sticky alert bit, set by hardware and cleared by a zero write
`timescale 1ns/10ps
`default_nettype none

module sticky_alert_bit (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_set,
    input wire logic i_clear,
    input wire logic i_clear_allow,
    output logic o_flag
);

    typedef struct packed {
        logic flag;
    } sticky_state_t;

    sticky_state_t state_r;
    sticky_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        // clear first so that a same-cycle event still lands
        if (i_clear && i_clear_allow) begin
            state_nxt.flag = 1'b0;
        end
        if (i_set) begin
            state_nxt.flag = 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_flag = state_r.flag;

endmodule
`default_nettype wire

// >>> rtl/progress_notice_timer.sv
// periodic progress tick generator for running balancing operations
`timescale 1ns/10ps
`default_nettype none
`include "balancing_alert_defines.svh"

module progress_notice_timer (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_run,
    input wire logic [1:0] i_cfg,
    output logic o_tick
);

    typedef struct packed {
        logic [`NOTICE_CNT_W-1:0] count;
        logic tick;
    } notice_state_t;

    notice_state_t state_r;
    notice_state_t state_nxt;
    logic [`NOTICE_CNT_W-1:0] period_last;

    always_comb begin
        unique case (i_cfg)
            2'h1: period_last = `NOTICE_CNT_W'(`NOTICE_SHORT_CYC - 1);
            2'h2: period_last = `NOTICE_CNT_W'(`NOTICE_MID_CYC - 1);
            2'h3: period_last = `NOTICE_CNT_W'(`NOTICE_LONG_CYC - 1);
            2'h0: period_last = '0;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        state_nxt.tick = 1'b0;
        // config 0 turns the notice off; stopping restarts the period
        if (!i_run || i_cfg == 2'h0) begin
            state_nxt.count = '0;
        end else if (state_r.count >= period_last) begin
            state_nxt.count = '0;
            state_nxt.tick = 1'b1;
        end else begin
            state_nxt.count = state_r.count + `NOTICE_CNT_W'(1);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_tick = state_r.tick;

endmodule
`default_nettype wire

// >>> rtl/balancing_alert_status.sv
// balancing alert status register bank with avalon-mm slave and interrupt
`timescale 1ns/10ps
`default_nettype none
`include "balancing_alert_defines.svh"

module balancing_alert_status (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire balancing_alert_pkg::avs_req_t i_avs,
    output balancing_alert_pkg::avs_rsp_t o_avs,
    input wire balancing_alert_pkg::bal_event_t i_bal,
    input wire balancing_alert_pkg::prot_write_t i_prot,
    output logic o_prot_write_commit,
    output logic o_prot_write_rejected,
    output logic [15:0] o_alert_summary,
    output logic o_irq
);

    import balancing_alert_pkg::*;

    // five summary alerts and the rejection flag
    localparam int N_FLAGS = 6;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    // ports are fed from these flops; summary and rejection lag a cycle
    typedef struct packed {
        bus_state_t bus;
        logic waitrequest;
        logic [`AVS_DATA_W-1:0] readdata;
        logic timeout_disable;
        logic thermal_check_enable;
        logic [1:0] notice_config;
        logic [15:0] irq_mask;
        logic [15:0] irq_status;
        logic [15:0] summary_out;
        logic rejected_out;
        logic commit;
        logic irq;
    } top_state_t;

    top_state_t state_r;
    top_state_t state_nxt;

    // flag order: 0 rejected, 1 finished, 2 progress, 3 calib, 4 thermal,
    // 5 watchdog
    logic [N_FLAGS-1:0] flag_set;
    logic [N_FLAGS-1:0] flag_clear;
    logic [N_FLAGS-1:0] flag_allow;
    logic [N_FLAGS-1:0] flag_q;
    logic notice_tick;
    logic notice_run;
    logic bus_req;
    logic bus_take;
    logic bus_wr;
    logic hi_lane;
    logic lo_lane;
    logic prot_busy;
    logic mode_disch_auto;
    logic [15:0] summary_view;
    logic [15:0] reject_view;
    logic [15:0] event_vec;
    logic [15:0] control_view;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    assign bus_req = i_avs.read || i_avs.write;
    // request is taken on the edge where waitrequest is seen low
    assign bus_take = bus_req && state_r.bus == BUS_ACK;
    assign bus_wr = bus_take && i_avs.write;
    // only the two low lanes carry register bits
    assign hi_lane = i_avs.byteenable[1];
    assign lo_lane = i_avs.byteenable[0];

    // ------------------------------------------------------------------
    // engine qualification
    // ------------------------------------------------------------------
    // manual runs never raise the watchdog or calibration halt
    assign mode_disch_auto = i_bal.mode == MODE_DISCHARGE ||
                             i_bal.mode == MODE_AUTO;
    // a scan alone is enough to refuse a protected write
    assign prot_busy = i_prot.scan_active || i_prot.gate_scan_active ||
                       i_bal.active;
    // notice only runs for discharge and automated operations
    assign notice_run = i_bal.active && mode_disch_auto;

    progress_notice_timer u_notice (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_run(notice_run),
        .i_cfg(state_r.notice_config),
        .o_tick(notice_tick)
    );

    // ------------------------------------------------------------------
    // sticky flag set terms
    // ------------------------------------------------------------------
    // pulses count on the edge where they are seen, in any order
    always_comb begin
        flag_set = '0;
        flag_set[0] = i_prot.write_req && prot_busy;
        flag_set[1] = i_bal.done_timer || i_bal.done_undervoltage;
        flag_set[2] = notice_tick;
        flag_set[3] = i_bal.calib_halt && mode_disch_auto;
        // manual runs also halt on thermal faults
        flag_set[4] = i_bal.thermal_halt &&
                      state_r.thermal_check_enable;
        flag_set[5] = i_bal.watchdog_halt && mode_disch_auto &&
                      !state_r.timeout_disable;
    end

    // ------------------------------------------------------------------
    // sticky flag clear terms
    // ------------------------------------------------------------------
    always_comb begin
        flag_clear = '0;
        flag_allow = '1;
        if (bus_wr && i_avs.address == `OFS_CMD_REJECT && lo_lane) begin
            flag_clear[0] = !i_avs.writedata[`BIT_REJECTED];
        end
        if (bus_wr && i_avs.address == `OFS_BAL_ALERT_SUMMARY &&
            hi_lane) begin
            // a one written leaves the bit as it is
            flag_clear[1] = !i_avs.writedata[`BIT_FINISHED];
            flag_clear[2] = !i_avs.writedata[`BIT_PROGRESS];
            flag_clear[3] = !i_avs.writedata[`BIT_CALIB_HALT];
            flag_clear[4] = !i_avs.writedata[`BIT_THERMAL_HALT];
            flag_clear[5] = !i_avs.writedata[`BIT_WATCHDOG_HALT];
        end
        // calibration and thermal halts must outlive the operation that caused them
        flag_allow[3] = !i_bal.active;
        flag_allow[4] = !i_bal.active;
    end

    // one cell per flag keeps set-over-clear priority in one place
    genvar gi;
    generate
        for (gi = 0; gi < N_FLAGS; gi++) begin : g_flag
            sticky_alert_bit u_bit (
                .i_mclk(i_mclk),
                .i_rst_b(i_rst_b),
                .i_set(flag_set[gi]),
                .i_clear(flag_clear[gi]),
                .i_clear_allow(flag_allow[gi]),
                .o_flag(flag_q[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // register views
    // ------------------------------------------------------------------
    always_comb begin
        // low bits are unused and always read zero
        summary_view = `SUMMARY_RESET;
        summary_view[`BIT_WATCHDOG_HALT] = flag_q[5];
        summary_view[`BIT_THERMAL_HALT] = flag_q[4];
        summary_view[`BIT_CALIB_HALT] = flag_q[3];
        summary_view[`BIT_PROGRESS] = flag_q[2];
        summary_view[`BIT_FINISHED] = flag_q[1];
        reject_view = '0;
        reject_view[`BIT_REJECTED] = flag_q[0];
        control_view = '0;
        control_view[`BIT_TIMEOUT_DISABLE] = state_r.timeout_disable;
        control_view[`BIT_THERMAL_ENABLE] = state_r.thermal_check_enable;
        control_view[`NOTICE_CFG_HI:`NOTICE_CFG_LO] = state_r.notice_config;
        // interrupt events share the summary layout plus rejection
        event_vec = '0;
        event_vec[`BIT_WATCHDOG_HALT] = flag_set[5];
        event_vec[`BIT_THERMAL_HALT] = flag_set[4];
        event_vec[`BIT_CALIB_HALT] = flag_set[3];
        event_vec[`BIT_PROGRESS] = flag_set[2];
        event_vec[`BIT_FINISHED] = flag_set[1];
        event_vec[`BIT_REJECTED] = flag_set[0];
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [15:0] w1c;
        logic [15:0] wmask;
        w1c = '0;
        // lanes above bit 15 hold no register bits
        wmask = {{8{hi_lane}}, {8{lo_lane}}};
        state_nxt = state_r;
        state_nxt.commit = 1'b0;

        // one wait cycle per access; readdata is settled before the ack
        unique case (state_r.bus)
            BUS_IDLE: begin
                if (bus_req) begin
                    state_nxt.bus = BUS_ACK;
                    state_nxt.waitrequest = 1'b0;
                    state_nxt.readdata = '0;
                    if (i_avs.read) begin
                        unique case (i_avs.address)
                            `OFS_BAL_CONTROL:
                                state_nxt.readdata[15:0] = control_view;
                            `OFS_BAL_ALERT_SUMMARY:
                                state_nxt.readdata[15:0] = summary_view;
                            `OFS_CMD_REJECT:
                                state_nxt.readdata[15:0] = reject_view;
                            `OFS_IRQ_MASK:
                                state_nxt.readdata[15:0] = state_r.irq_mask;
                            `OFS_IRQ_STATUS:
                                state_nxt.readdata[15:0] =
                                    state_r.irq_status;
                            // unmapped offsets still answer, with zero data
                            default: state_nxt.readdata = '0;
                        endcase
                    end
                end
            end
            BUS_ACK: begin
                state_nxt.bus = BUS_IDLE;
                state_nxt.waitrequest = 1'b1;
            end
        endcase

        if (bus_wr) begin
            unique case (i_avs.address)
                `OFS_BAL_CONTROL: begin
                    if (lo_lane) begin
                        state_nxt.timeout_disable =
                            i_avs.writedata[`BIT_TIMEOUT_DISABLE];
                        state_nxt.thermal_check_enable =
                            i_avs.writedata[`BIT_THERMAL_ENABLE];
                        state_nxt.notice_config =
                            i_avs.writedata[`NOTICE_CFG_HI:`NOTICE_CFG_LO];
                    end
                end
                // mask bits outside the event layout stay zero
                `OFS_IRQ_MASK: begin
                    state_nxt.irq_mask = (state_r.irq_mask & ~wmask) |
                        (i_avs.writedata[15:0] & wmask & `IRQ_LAYOUT);
                end
                `OFS_IRQ_STATUS: begin
                    w1c = i_avs.writedata[15:0] & wmask;
                end
                default: begin
                end
            endcase
        end

        // a new event wins over a same-cycle write-one clear
        state_nxt.irq_status = (state_r.irq_status & ~w1c) | event_vec;

        // protected writes pass only while nothing is running
        state_nxt.commit = i_prot.write_req && !prot_busy;

        state_nxt.summary_out = summary_view;
        state_nxt.rejected_out = flag_q[0];
        // next copies used so irq rises with the status bit
        state_nxt.irq = |(state_nxt.irq_status & state_nxt.irq_mask);
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= '0;
            state_r.bus <= BUS_IDLE;
            state_r.waitrequest <= 1'b1;
            state_r.notice_config <= 2'(`CONTROL_RESET >> `NOTICE_CFG_LO);
            state_r.irq_mask <= `IRQ_RESET;
            state_r.irq_status <= `IRQ_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // waitrequest is high except in the single ack cycle
    assign o_avs.waitrequest = state_r.waitrequest;
    // readdata holds until the next access loads it; a write loads zero
    assign o_avs.readdata = state_r.readdata;
    assign o_prot_write_commit = state_r.commit;
    assign o_prot_write_rejected = state_r.rejected_out;
    assign o_alert_summary = state_r.summary_out;
    assign o_irq = state_r.irq;

endmodule
`default_nettype wire

// >>> tb/balancing_alert_status_properties.sv
// port assertions for the balancing alert status block
`timescale 1ns/10ps
`default_nettype none
`include "balancing_alert_defines.svh"

module balancing_alert_checker (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire balancing_alert_pkg::avs_req_t i_avs,
    input wire balancing_alert_pkg::avs_rsp_t o_avs,
    input wire balancing_alert_pkg::bal_event_t i_bal,
    input wire balancing_alert_pkg::prot_write_t i_prot,
    input wire logic o_prot_write_commit,
    input wire logic o_prot_write_rejected,
    input wire logic [15:0] o_alert_summary,
    input wire logic o_irq
);
    import balancing_alert_pkg::*;
    // ------------------------------------------------------------
    // control shadow, loaded at the ack edge like the real register
    // ------------------------------------------------------------
    logic [3:0] ctl_r;
    logic busy;
    logic nm;
    assign busy = i_prot.scan_active | i_prot.gate_scan_active | i_bal.active;
    assign nm = i_bal.mode != MODE_MANUAL;
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctl_r <= 4'h0;
        end else if (i_avs.write && !o_avs.waitrequest && i_avs.byteenable[0]
                     && i_avs.address == `OFS_BAL_CONTROL) begin
            ctl_r <= i_avs.writedata[3:0];
        end
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    // ------------------------------------------------------------
    // properties; summary output trails the flags by one cycle
    // ------------------------------------------------------------
    unused_zero_a: assert property (
        o_alert_summary[10:0] == 11'h0) else $error("summary low bits set");
    reject_set_a: assert property (
        i_prot.write_req && busy |=> ##1 o_prot_write_rejected)
        else $error("busy write not flagged");
    commit_gate_a: assert property (
        i_prot.write_req |=> o_prot_write_commit == !$past(busy))
        else $error("commit does not follow busy state");
    watchdog_set_a: assert property (
        i_bal.watchdog_halt && nm && !ctl_r[0] |=> ##1 o_alert_summary[15])
        else $error("watchdog halt not latched");
    thermal_set_a: assert property (
        i_bal.thermal_halt && ctl_r[1] |=> ##1 o_alert_summary[14])
        else $error("thermal halt not latched");
    calib_set_a: assert property (
        i_bal.calib_halt && nm |=> ##1 o_alert_summary[13])
        else $error("calibration halt not latched");
    finish_set_a: assert property (
        i_bal.done_timer || i_bal.done_undervoltage
        |=> ##1 o_alert_summary[11]) else $error("finish not latched");
    hold_running_a: assert property (
        i_bal.active ##1 1'b1 |=> (o_alert_summary[14:13]
        & $past(o_alert_summary[14:13])) == $past(o_alert_summary[14:13]))
        else $error("halt bit cleared while running");
endmodule

bind balancing_alert_status balancing_alert_checker i_checker (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_avs(i_avs),
    .o_avs(o_avs),
    .i_bal(i_bal),
    .i_prot(i_prot),
    .o_prot_write_commit(o_prot_write_commit),
    .o_prot_write_rejected(o_prot_write_rejected),
    .o_alert_summary(o_alert_summary),
    .o_irq(o_irq)
);
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the balancing alert status block
`timescale 1ns/10ps
`default_nettype none
`include "balancing_alert_defines.svh"

module tb_top;
    import balancing_alert_pkg::*;
    logic i_mclk;
    logic i_rst_b;
    avs_req_t avs;
    avs_rsp_t rsp;
    bal_event_t bal;
    prot_write_t prot;
    logic commit;
    logic rej;
    logic irq;
    logic [15:0] summ;
    logic [15:0] exp_s;
    logic [15:0] w;
    logic [31:0] q;
    logic [4:0] p;
    logic [3:0] ctl;
    logic [1:0] c;
    int bad_count;
    int n_checks;
    int seed;
    int i;

    balancing_alert_status i_balancing_alert_status (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_avs(avs), .o_avs(rsp),
        .i_bal(bal), .i_prot(prot), .o_prot_write_commit(commit),
        .o_prot_write_rejected(rej), .o_alert_summary(summ), .o_irq(irq)
    );

    always #25 i_mclk = ~i_mclk;

    // ------------------------------------------------------------
    // bus, event and checking helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until waitrequest is sampled low
    task automatic xfer(input logic wr_en, input logic [4:0] a,
                        input logic [15:0] d, output logic [31:0] rq);
        @(posedge i_mclk);
        avs.read <= ~wr_en;
        avs.write <= wr_en;
        avs.address <= a;
        avs.writedata <= {16'h0, d};
        @(posedge i_mclk);
        // no cycle count assumed; the watchdog ends a hung access
        while (rsp.waitrequest !== 1'b0) begin
            @(posedge i_mclk);
        end
        rq = rsp.readdata;
        avs.read <= 1'b0;
        avs.write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [31:0] dummy;
        xfer(1'b1, a, d, dummy);
    endtask

    task automatic fire(input logic [4:0] e);
        @(posedge i_mclk);
        bal[4:0] <= e;
        @(posedge i_mclk);
        bal[4:0] <= 5'h0;
    endtask

    function automatic logic [15:0] set_of(logic [4:0] e, bal_mode_t m,
                                           logic [3:0] k);
        logic nm;
        nm = m != MODE_MANUAL;
        return {e[4] & nm & ~k[0], e[3] & k[1], e[2] & nm, 1'b0,
                e[1] | e[0], 11'h0};
    endfunction

    function automatic int period(input logic [1:0] k);
        case (k)
            2'h2: return `NOTICE_MID_CYC;
            2'h3: return `NOTICE_LONG_CYC;
            default: return `NOTICE_SHORT_CYC;
        endcase
    endfunction

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        i_mclk = 1'b0;
        i_rst_b = 1'b0;
        avs = '0;
        avs.byteenable = 4'hf;
        bal = '0;
        prot = '0;
        exp_s = '0;
        bad_count = 0;
        n_checks = 0;
        seed = 32'h3223;
        repeat (16) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        for (i = 0; i < 6; i++) begin
            xfer(1'b0, 5'(i * 4), 16'h0, q);
            chk(q, 32'h0);
        end
        $display("test reset values done");
        // scan, gating scan, balancing, then idle
        for (i = 0; i < 4; i++) begin
            @(posedge i_mclk);
            {prot.scan_active, prot.gate_scan_active, bal.active} <= 3'h4 >> i;
            prot.write_req <= 1'b1;
            @(posedge i_mclk);
            prot.write_req <= 1'b0;
            @(posedge i_mclk);
            chk(32'(commit), 32'(i == 3));
            wr(`OFS_CMD_REJECT, 16'hffff);
            xfer(1'b0, `OFS_CMD_REJECT, 16'h0, q);
            chk(q, 32'(i < 3));
            chk(32'(rej), 32'(i < 3));
            wr(`OFS_CMD_REJECT, 16'h0);
        end
        $display("test protected write done");
        for (i = 0; i < 40; i++) begin
            ctl = 4'($random(seed)) & 4'h3;
            wr(`OFS_BAL_CONTROL, {12'h0, ctl});
            @(posedge i_mclk);
            bal.active <= (i == 0) ? 1'b1 : 1'($random(seed));
            bal.mode <= bal_mode_t'(2'({$random(seed)} % 3));
            p = (i < 3) ? 5'h1f : 5'($random(seed));
            fire(p);
            exp_s = exp_s | set_of(p, bal.mode, ctl);
            xfer(1'b0, `OFS_BAL_ALERT_SUMMARY, 16'h0, q);
            chk(q, {16'h0, exp_s});
            chk({16'h0, summ}, {16'h0, exp_s});
            w = (i < 2) ? 16'h0 : 16'($random(seed));
            wr(`OFS_BAL_ALERT_SUMMARY, w);
            exp_s = exp_s & (w | (bal.active ? 16'h6000 : 16'h0));
            xfer(1'b0, `OFS_BAL_ALERT_SUMMARY, 16'h0, q);
            chk(q, {16'h0, exp_s});
        end
        $display("test random events done");
        bal.active <= 1'b0;
        wr(`OFS_IRQ_STATUS, 16'hffff);
        wr(`OFS_BAL_CONTROL, 16'h2);
        fire(5'h08);
        xfer(1'b0, `OFS_IRQ_STATUS, 16'h0, q);
        chk(q, 32'h4000);
        chk(32'(irq), 32'h0);
        // low lane only: the summary bits must survive a zero write
        avs.byteenable <= 4'h1;
        wr(`OFS_BAL_ALERT_SUMMARY, 16'h0);
        avs.byteenable <= 4'hf;
        xfer(1'b0, `OFS_BAL_ALERT_SUMMARY, 16'h0, q);
        chk(q, {16'h0, exp_s | 16'h4000});
        wr(`OFS_IRQ_MASK, 16'hffff);
        xfer(1'b0, `OFS_IRQ_MASK, 16'h0, q);
        chk(q, 32'(`IRQ_LAYOUT));
        repeat (2) @(posedge i_mclk);
        chk(32'(irq), 32'h1);
        wr(`OFS_IRQ_STATUS, 16'h4000);
        repeat (2) @(posedge i_mclk);
        chk(32'(irq), 32'h0);
        wr(5'h14, 16'hffff);
        xfer(1'b0, 5'h14, 16'h0, q);
        chk(q, 32'h0);
        xfer(1'b0, `OFS_BAL_CONTROL, 16'h0, q);
        chk(q, 32'h2);
        $display("test interrupt and map done");
        // notice periods per config; last pass is a manual run
        for (i = 0; i < 5; i++) begin
            c = (i < 4) ? 2'(i) : 2'h1;
            wr(`OFS_BAL_CONTROL, {12'h0, c, 2'h0});
            wr(`OFS_BAL_ALERT_SUMMARY, 16'h0);
            @(posedge i_mclk);
            bal.mode <= (i == 4) ? MODE_MANUAL
                        : (i[0] ? MODE_AUTO : MODE_DISCHARGE);
            bal.active <= 1'b1;
            repeat (period(c) - 5) @(posedge i_mclk);
            chk(32'(summ[12]), 32'h0);
            repeat (20) @(posedge i_mclk);
            chk(32'(summ[12]), 32'(c != 2'h0 && i < 4));
            bal.active <= 1'b0;
        end
        $display("test progress notice done");
        report_and_stop();
    end

    initial begin
        repeat (40000) @(posedge i_mclk);
        bad_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
